// ---- rtl/bdr_bridge_ctrl.sv ----
// bridge gate drive: direct passthrough or self-switching oscillator
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/10ps
`include "bdr_defs.svh"

// Summary of operation
// - enable high: source select picks mode
// - direct mode forwards phase inputs to gates
// - dead time between high and low gates
// - pulses of 50 ns or longer propagate at a dead setting of 0 or 1
// - strobe rise moves exactly one step
// - self-switching restarts at 175 kHz
// - rate echo 50 percent, rises with leg A
// - direction low raises frequency one step
// - direction high lowers frequency one step
// - duty stepping only with mode high
// - direction low reduces duty one step
// - duty never below 10 percent
// - direction high raises duty one step
// - duty never above 50 percent
// - frequency steps resume at full duty, mode low
// - frequency stays 110 to 205 kHz
module bdr_bridge_ctrl (
  input  wire logic            clk_sys,
  input  wire logic            clk_link,
  input  wire logic            rst_b,
  input  wire logic            enable,
  input  wire logic            drive_src_sel,
  input  wire logic            step_mode,
  input  wire logic            phase_a_drive_in,
  input  wire logic            phase_b_drive_in,
  output bdr_pkg::bdr_gate_t   gate_leg_a,
  output bdr_pkg::bdr_gate_t   gate_leg_b,
  output logic                 rate_echo,
  input  wire logic [3:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  input  wire logic [3:0]      avs_byteenable,
  output logic [31:0]          avs_readdata,
  output logic                 avs_waitrequest
);
  import bdr_pkg::*;

  // period taps bound the frequency range
  localparam logic [8:0] P_START = 9'(`BDR_PERIOD_START);
  localparam logic [8:0] P_MIN   = 9'(`BDR_PERIOD_MIN);
  localparam logic [8:0] P_MAX   = 9'(`BDR_PERIOD_MAX);
  localparam logic [3:0] D_MIN   = 4'(`BDR_DUTY_MIN_POS);
  localparam logic [3:0] D_MAX   = 4'(`BDR_DUTY_MAX_POS);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  bdr_pins_t pins_raw;
  bdr_pins_t pins_m;
  bdr_pins_t pins_s;

  assign pins_raw = '{enable, drive_src_sel, step_mode, phase_a_drive_in, phase_b_drive_in};

  // two flops before any logic reads a pin
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pins_m <= '0;
      pins_s <= '0;
    end
    else
    begin
      pins_m <= pins_raw;
      pins_s <= pins_m;
    end
  end

  // ----------------------------------------
  // strobe events from the link domain
  // ----------------------------------------
  logic ev;
  logic ev_dir;

  bdr_strobe_link u_link (
    .clk_link   (clk_link),
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .strobe_pin (phase_a_drive_in),
    .dir_pin    (phase_b_drive_in),
    .ev         (ev),
    .ev_dir     (ev_dir)
  );

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [3:0] dead_cfg;
  logic [3:0] step_cfg;
  wire  [8:0] step = {5'h00, step_cfg};

  // ----------------------------------------
  // operating mode
  // ----------------------------------------
  bdr_op_t    op;
  bdr_op_t    next_op;
  logic [8:0] period;
  logic [3:0] duty_pos;
  logic [8:0] cnt;

  wire from_stop = (op == BDR_OFF) || (op == BDR_DIRECT);
  wire at_full   = (duty_pos == D_MAX);

  // back to frequency stepping at full duty only
  assign next_op = !pins_s.enable   ? BDR_OFF :
                   pins_s.src_sel   ? BDR_DIRECT :
                   from_stop        ? BDR_SELF :
                   pins_s.step_mode ? BDR_DUTY :
                   at_full          ? BDR_SELF : BDR_DUTY;

  wire restart = (next_op == BDR_SELF) && from_stop;

  // strobe qualifiers for each kind of step
  wire f_step   = ev && (op == BDR_SELF) && !pins_s.step_mode;
  wire d_step   = ev && (op == BDR_DUTY) && pins_s.step_mode;
  wire f_up_ok  = (period >= P_MIN + step);
  wire f_dn_ok  = (period + step <= P_MAX);

  // strobe with direction low shortens the period
  // steps past either end are dropped
  wire [8:0] next_period = restart                     ? P_START :
                           (f_step && !ev_dir && f_up_ok) ? period - step :
                           (f_step && ev_dir && f_dn_ok)  ? period + step : period;

  // duty steps only in duty mode with mode high
  wire [3:0] next_duty = restart                                ? D_MAX :
                         (d_step && !ev_dir && duty_pos > D_MIN) ? duty_pos - 4'h1 :
                         (d_step && ev_dir && duty_pos < D_MAX)  ? duty_pos + 4'h1 : duty_pos;

  // mode, period and duty registers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      op       <= BDR_OFF;
      period   <= P_START;
      duty_pos <= D_MAX;
    end
    else
    begin
      op       <= next_op;
      period   <= next_period;
      duty_pos <= next_duty;
    end
  end

  // ----------------------------------------
  // internal oscillator
  // ----------------------------------------
  wire        self_run = (op == BDR_SELF) || (op == BDR_DUTY);
  wire [12:0] hi_prod  = {4'h0, period} * {9'h000, duty_pos};
  wire [8:0]  hi_cnt   = 9'(hi_prod / 13'(`BDR_DUTY_DEN));
  wire [8:0]  half     = {1'b0, period[8:1]};
  // a zero dead setting counts as one cycle, as at the gates
  wire [8:0]  echo_off = half + {5'h00, dead_cfg} + ((dead_cfg == 4'h0) ? 9'h001 : 9'h000);
  wire        wrap     = (cnt >= period - 9'h001);
  wire        cmd_a_s  = (cnt < hi_cnt);
  wire        cmd_b_s  = (cnt >= half) && (cnt < half + hi_cnt);

  // period counter, restarts on entry to self-switching from off or direct
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      cnt <= 9'h000;
    else if (!self_run || restart || wrap)
      cnt <= 9'h000;
    else
      cnt <= cnt + 9'h001;
  end

  // ----------------------------------------
  // per-leg dead-time gate drive
  // ----------------------------------------
  bdr_gate_t gate [2];
  wire [1:0] cmd_direct = {pins_s.ph_b, pins_s.ph_a};
  wire [1:0] cmd_self   = {cmd_b_s, cmd_a_s};
  wire       drive_on   = (op != BDR_OFF);
  wire [3:0] dead_load  = (dead_cfg == 4'h0) ? 4'h0 : dead_cfg - 4'h1;

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_leg
      logic      [3:0] dcnt;
      wire             cmd     = (op == BDR_DIRECT) ? cmd_direct[i] : cmd_self[i];
      wire             on_ok   = cmd ? gate[i].hi : gate[i].lo;
      wire             any_on  = gate[i].hi | gate[i].lo;

      // follow the phase input in direct mode
      // both gates off for the dead time on a change
      // no filtering beyond the dead time
      always_ff @(posedge clk_sys or negedge rst_b)
      begin
        if (!rst_b)
        begin
          gate[i] <= '0;
          dcnt    <= 4'h0;
        end
        else if (!drive_on)
        begin
          gate[i] <= '0;
          dcnt    <= 4'h0;
        end
        else if (on_ok)
          dcnt <= 4'h0;
        else if (any_on)
        begin
          gate[i] <= '0;        // break before make
          dcnt    <= dead_load;
        end
        else if (dcnt != 4'h0)
          dcnt <= dcnt - 4'h1;
        else
          gate[i] <= cmd ? 2'b10 : 2'b01;
      end
    end
  endgenerate

  assign gate_leg_a = gate[0];
  assign gate_leg_b = gate[1];

  // ----------------------------------------
  // rate echo
  // ----------------------------------------
  wire a_hi_rise = !gate[0].hi && cmd_a_s && !gate[0].lo && (g_leg[0].dcnt == 4'h0) && self_run;

  // rises with leg A high gate, falls half a period later
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rate_echo <= 1'b0;
    else if (!self_run)
      rate_echo <= 1'b0;
    else if (a_hi_rise)
      rate_echo <= 1'b1;
    else if (cnt == echo_off)
      rate_echo <= 1'b0;
  end

  // ----------------------------------------
  // avalon slave, one wait cycle per access
  // ----------------------------------------
  wire req      = avs_read | avs_write;
  wire sel_stat = (avs_address == `BDR_REG_STATUS);
  wire sel_per  = (avs_address == `BDR_REG_PERIOD);
  wire sel_ctrl = (avs_address == `BDR_REG_CTRL);
  wire wr_ctrl  = avs_write && !avs_waitrequest && sel_ctrl;
  wire [31:0] stat_word = {22'h000000, duty_pos, rate_echo, pins_s.enable, op, 2'b00};
  wire [31:0] rd_word   = sel_stat ? stat_word :
                          sel_per  ? {23'h000000, period} :
                          sel_ctrl ? {20'h00000, step_cfg, 4'h0, dead_cfg} : 32'h00000000;

  // waitrequest drops for the cycle after the request is seen
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end
    else if (req && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_word : 32'h00000000;
    end
    else
      avs_waitrequest <= 1'b1;
  end

  // control register, written on the accepting edge
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dead_cfg <= 4'(`BDR_DEAD_CYC);
      step_cfg <= 4'(`BDR_FREQ_STEP_CYC);
    end
    else if (wr_ctrl)
    begin
      if (avs_byteenable[0])
        dead_cfg <= avs_writedata[`BDR_CTRL_DEAD_LSB +: 4];
      if (avs_byteenable[1])
        step_cfg <= (avs_writedata[`BDR_CTRL_STEP_LSB +: 4] == 4'h0) ? 4'h1
                                                                      : avs_writedata[`BDR_CTRL_STEP_LSB +: 4];
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_mode_direct : assert property (@(posedge clk_sys) disable iff (!rst_b)
    pins_s.enable && pins_s.src_sel |=> op == BDR_DIRECT)
    else $error("direct mode not entered");

  a_pass_high : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (op == BDR_DIRECT && pins_s.ph_a && dead_cfg == 4'h1)[*4] |-> gate_leg_a.hi)
    else $error("phase A not forwarded");

  a_dead_gap : assert property (@(posedge clk_sys) disable iff (!rst_b)
    $fell(gate_leg_a.hi) |-> !gate_leg_a.lo ##1 !gate_leg_a.hi)
    else $error("no dead time on leg A");

  a_no_shoot : assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(gate_leg_b.hi && gate_leg_b.lo))
    else $error("leg B shoot through");

  a_restart_tap : assert property (@(posedge clk_sys) disable iff (!rst_b)
    op == BDR_DIRECT ##1 op == BDR_SELF |-> period == P_START && duty_pos == D_MAX)
    else $error("self-switching start tap wrong");

  a_echo_align : assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(rate_echo) |-> $rose(gate_leg_a.hi))
    else $error("echo not aligned with leg A");

  a_freq_up : assert property (@(posedge clk_sys) disable iff (!rst_b)
    f_step && !ev_dir && f_up_ok && !restart |=> period == $past(period) - $past(step))
    else $error("frequency step up wrong");

  a_freq_down : assert property (@(posedge clk_sys) disable iff (!rst_b)
    f_step && ev_dir && f_dn_ok && !restart |=> period == $past(period) + $past(step))
    else $error("frequency step down wrong");

  a_duty_down : assert property (@(posedge clk_sys) disable iff (!rst_b)
    d_step && !ev_dir && duty_pos > D_MIN |=> duty_pos == $past(duty_pos) - 4'h1)
    else $error("duty step down wrong");

  a_duty_range : assert property (@(posedge clk_sys) disable iff (!rst_b)
    duty_pos >= D_MIN && duty_pos <= D_MAX)
    else $error("duty position out of range");

  a_full_duty : assert property (@(posedge clk_sys) disable iff (!rst_b)
    op == BDR_SELF |-> duty_pos == D_MAX)
    else $error("frequency mode below full duty");

  a_freq_range : assert property (@(posedge clk_sys) disable iff (!rst_b)
    period >= P_MIN && period <= P_MAX)
    else $error("period out of range");

  a_off_gates : assert property (@(posedge clk_sys) disable iff (!rst_b)
    !pins_s.enable ##1 1'b1 |=> gate_leg_a == 2'b00 && gate_leg_b == 2'b00)
    else $error("gates on while disabled");

endmodule : bdr_bridge_ctrl

// ---- rtl/bdr_defs.svh ----
// constants for the bridge drive rate and duty control block
`ifndef BDR_DEFS_SVH
`define BDR_DEFS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define BDR_CLK_SYS_KHZ      50000
`define BDR_CLK_PERIOD_NS    20
`define BDR_DEAD_TIME_NS     20
`define BDR_DEAD_RAW         (`BDR_DEAD_TIME_NS / `BDR_CLK_PERIOD_NS)
`define BDR_DEAD_CYC         ((`BDR_DEAD_RAW > 0) ? `BDR_DEAD_RAW : 1)
`define BDR_MIN_PULSE_NS     50

// ----------------------------------------
// frequency taps, as oscillator periods in clk_sys cycles
// ----------------------------------------
`define BDR_FREQ_START_KHZ   175
`define BDR_FREQ_MAX_KHZ     205
`define BDR_FREQ_MIN_KHZ     110
`define BDR_PERIOD_START     (`BDR_CLK_SYS_KHZ / `BDR_FREQ_START_KHZ)
`define BDR_PERIOD_MIN       (`BDR_CLK_SYS_KHZ / `BDR_FREQ_MAX_KHZ)
`define BDR_PERIOD_MAX       (`BDR_CLK_SYS_KHZ / `BDR_FREQ_MIN_KHZ)
`define BDR_FREQ_STEP_CYC    1

// ----------------------------------------
// duty positions in units of 1/20 of a period (5 percent)
// ----------------------------------------
`define BDR_DUTY_DEN         20
`define BDR_DUTY_MIN_POS     2
`define BDR_DUTY_MAX_POS     10

// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define BDR_REG_STATUS       4'h0
`define BDR_REG_PERIOD       4'h4
`define BDR_REG_CTRL         4'h8
`define BDR_CTRL_DEAD_LSB    0
`define BDR_CTRL_STEP_LSB    8

`endif

// ---- rtl/bdr_pkg.sv ----
// types shared by the bridge drive rate and duty control block
package bdr_pkg;

  // operating mode, gray coded along off-direct-self-duty
  typedef enum logic [1:0] {
    BDR_OFF    = 2'b00,
    BDR_DIRECT = 2'b01,
    BDR_SELF   = 2'b11,
    BDR_DUTY   = 2'b10
  } bdr_op_t;

  // gate pair of one bridge leg
  typedef struct packed {
    logic hi;
    logic lo;
  } bdr_gate_t;

  // controller pins after synchronisation
  typedef struct packed {
    logic enable;
    logic src_sel;
    logic step_mode;
    logic ph_a;
    logic ph_b;
  } bdr_pins_t;

endpackage : bdr_pkg

// ---- rtl/bdr_strobe_link.sv ----
// strobe capture on the link clock and event crossing to clk_sys
`timescale 1ns/10ps
module bdr_strobe_link (
  input  wire logic clk_link,
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic strobe_pin,
  input  wire logic dir_pin,
  output logic      ev,
  output logic      ev_dir
);

  // ----------------------------------------
  // link domain
  // ----------------------------------------
  logic s1, s2, s3;
  logic d1, d2;
  logic tog;
  logic dir_hold;
  wire  rise_l = s2 & ~s3;

  // two-flop sync of strobe and direction, then edge capture
  always_ff @(posedge clk_link or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1       <= 1'b0;
      s2       <= 1'b0;
      s3       <= 1'b0;
      d1       <= 1'b0;
      d2       <= 1'b0;
      tog      <= 1'b0;
      dir_hold <= 1'b0;
    end
    else
    begin
      s1 <= strobe_pin;
      s2 <= s1;
      s3 <= s2;
      d1 <= dir_pin;
      d2 <= d1;
      if (rise_l)
      begin
        tog      <= ~tog;  // one toggle per rising edge
        dir_hold <= d2;    // direction held until next strobe
      end
    end
  end

  // ----------------------------------------
  // system domain
  // ----------------------------------------
  logic t1, t2, t3;
  wire  flip = t2 ^ t3;

  // toggle sync into clk_sys, one pulse per strobe
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      t1     <= 1'b0;
      t2     <= 1'b0;
      t3     <= 1'b0;
      ev     <= 1'b0;
      ev_dir <= 1'b0;
    end
    else
    begin
      t1 <= tog;
      t2 <= t1;
      t3 <= t2;
      ev <= flip;
      if (flip)
        ev_dir <= dir_hold;  // stable well before the toggle lands
    end
  end

endmodule : bdr_strobe_link

// ---- test/bdr_ctrl_model.sv ----
// controller model that drives the phase, strobe and direction pins
`timescale 1ns/10ps
module bdr_ctrl_model (
  input  wire logic clk_link,
  output logic      pin_a,
  output logic      pin_b
);
  // pins idle low, as the pull-downs leave them
  initial
  begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // direct drive of both phases on a link edge
  task automatic set_pins(input logic a, input logic b);
    @(posedge clk_link);
    pin_a <= a;
    pin_b <= b;
  endtask : set_pins

  // n strobes, direction settled three periods ahead of each
  task automatic step(input logic dir, input int n);
    repeat (n)
    begin
      set_pins(1'b0, dir);
      repeat (3) @(posedge clk_link);
      pin_a <= 1'b1;
      repeat (3) @(posedge clk_link);
      pin_a <= 1'b0;
      repeat (6) @(posedge clk_link);
    end
  endtask : step
endmodule : bdr_ctrl_model

// ---- test/tb_bridge_drive_rate_duty_control.sv ----
// self-checking bench for the bridge drive rate and duty control block
`timescale 1ns/10ps
`include "bdr_defs.svh"
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb_bridge_drive_rate_duty_control;
  import bdr_pkg::*;
  // ----
  // clocks, pins and bus
  // ----
  logic        clk_sys = 1'b0;
  logic        clk_link = 1'b0;
  logic        rst_b = 1'b0;
  logic        enable = 1'b0;
  logic        src_sel = 1'b1;
  logic        step_mode = 1'b0;
  logic        ph_a;
  logic        ph_b;
  bdr_gate_t   gate_leg_a;
  bdr_gate_t   gate_leg_b;
  logic        rate_echo;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] d;
  logic        seen_hi;
  int          err_count = 0;
  int          n_tests = 0;

  always #10 clk_sys = ~clk_sys;
  always #32 clk_link = ~clk_link;

  bdr_ctrl_model ctl (.clk_link(clk_link), .pin_a(ph_a), .pin_b(ph_b));

  bdr_bridge_ctrl dut (.clk_sys(clk_sys), .clk_link(clk_link), .rst_b(rst_b), .enable(enable),
    .drive_src_sel(src_sel), .step_mode(step_mode), .phase_a_drive_in(ph_a),
    .phase_b_drive_in(ph_b), .gate_leg_a(gate_leg_a), .gate_leg_b(gate_leg_b),
    .rate_echo(rate_echo), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // ----
  // monitors
  // ----
  always @(posedge clk_sys)
  begin
    if (gate_leg_a.hi)
      seen_hi <= 1'b1;
    if ((gate_leg_a.hi && gate_leg_a.lo) || (gate_leg_b.hi && gate_leg_b.lo))
      `CHK("leg_overlap", 1'b0, 1'b1)
  end

  // ----
  // helpers
  // ----
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic timeout;
    err_count++;
    complete_run();
  endtask : timeout

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd,
                     input logic [3:0] be);
    int k;
    @(posedge clk_sys);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0)
        break;
    end
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k == 50)
      timeout();
  endtask : bus

  task automatic pins(input logic en, input logic src, input logic md);
    @(posedge clk_sys);
    enable <= en;
    src_sel <= src;
    step_mode <= md;
    repeat (10) @(posedge clk_sys);
  endtask : pins

  // echo period and high time against the expected period
  task automatic echo(input int p);
    int k;
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    for (k = 0; k < 1000 && rate_echo !== 1'b0; k++) @(posedge clk_sys);
    if (k == 1000)
      timeout();
    for (k = 0; k < 1000 && rate_echo !== 1'b1; k++) @(posedge clk_sys);
    if (k == 1000)
      timeout();
    `CHK("echo_with_leg_a", 1'b1, gate_leg_a.hi)
    while (rate_echo === 1'b1 && hi < 1000) begin @(posedge clk_sys); hi++; end
    while (rate_echo === 1'b0 && lo < 1000) begin @(posedge clk_sys); lo++; end
    `CHK("echo_period", p, hi + lo)
    `CHK("echo_high", p / 2, hi)
  endtask : echo

  // ----
  // scenarios
  // ----
  task automatic t_regs;
    bus(1'b0, `BDR_REG_CTRL, 32'h0, 4'hf);
    `CHK("ctrl_reset", 32'h101, d)
    bus(1'b0, 4'hc, 32'h0, 4'hf);
    `CHK("unmapped", 32'h0, d)
    bus(1'b1, `BDR_REG_CTRL, 32'h305, 4'h1);
    bus(1'b0, `BDR_REG_CTRL, 32'h0, 4'hf);
    `CHK("ctrl_lane0", 32'h105, d)
    bus(1'b1, `BDR_REG_CTRL, 32'h001, 4'h3);
    bus(1'b0, `BDR_REG_CTRL, 32'h0, 4'hf);
    `CHK("ctrl_step_zero", 32'h101, d)
    $display("test regs done");
  endtask : t_regs

  task automatic t_off;
    pins(1'b0, 1'b1, 1'b1);
    ctl.set_pins(1'b1, 1'b1);
    repeat (10) @(posedge clk_sys);
    `CHK("off_leg_a", 2'b00, gate_leg_a)
    `CHK("off_leg_b", 2'b00, gate_leg_b)
    bus(1'b0, `BDR_REG_STATUS, 32'h0, 4'hf);
    `CHK("off_op", BDR_OFF, d[3:2])
    $display("test off done");
  endtask : t_off

  task automatic t_direct;
    pins(1'b1, 1'b1, 1'b0);
    bus(1'b0, `BDR_REG_STATUS, 32'h0, 4'hf);
    `CHK("direct_op", BDR_DIRECT, d[3:2])
    ctl.set_pins(1'b0, 1'b1);
    repeat (10) @(posedge clk_sys);
    `CHK("dir_leg_a_lo", 2'b01, gate_leg_a)
    `CHK("dir_leg_b_hi", 2'b10, gate_leg_b)
    ctl.set_pins(1'b1, 1'b0);
    repeat (10) @(posedge clk_sys);
    `CHK("dir_leg_a_hi", 2'b10, gate_leg_a)
    `CHK("dir_leg_b_lo", 2'b01, gate_leg_b)
    ctl.set_pins(1'b0, 1'b0);
    repeat (10) @(posedge clk_sys);
    seen_hi <= 1'b0;
    ctl.set_pins(1'b1, 1'b0);
    ctl.set_pins(1'b0, 1'b0);
    repeat (10) @(posedge clk_sys);
    `CHK("short_pulse", 1'b1, seen_hi)
    $display("test direct done");
  endtask : t_direct

  task automatic period_is(input int p);
    repeat (10) @(posedge clk_sys);
    bus(1'b0, `BDR_REG_PERIOD, 32'h0, 4'hf);
    `CHK("period", p, d[8:0])
  endtask : period_is

  task automatic t_freq;
    pins(1'b1, 1'b0, 1'b0);
    bus(1'b0, `BDR_REG_STATUS, 32'h0, 4'hf);
    `CHK("self_op", BDR_SELF, d[3:2])
    period_is(`BDR_PERIOD_START);
    echo(`BDR_PERIOD_START);
    ctl.step(1'b0, 1);
    period_is(`BDR_PERIOD_START - 1);
    ctl.step(1'b1, 2);
    period_is(`BDR_PERIOD_START + 1);
    ctl.step(1'b1, `BDR_PERIOD_MAX - `BDR_PERIOD_START + 2);
    period_is(`BDR_PERIOD_MAX);
    ctl.step(1'b0, `BDR_PERIOD_MAX - `BDR_PERIOD_MIN + 2);
    period_is(`BDR_PERIOD_MIN);
    echo(`BDR_PERIOD_MIN);
    $display("test freq done");
  endtask : t_freq

  task automatic duty_is(input int p);
    repeat (10) @(posedge clk_sys);
    bus(1'b0, `BDR_REG_STATUS, 32'h0, 4'hf);
    `CHK("duty_pos", p, d[9:6])
  endtask : duty_is

  task automatic t_duty;
    pins(1'b1, 1'b0, 1'b1);
    bus(1'b0, `BDR_REG_STATUS, 32'h0, 4'hf);
    `CHK("duty_op", BDR_DUTY, d[3:2])
    ctl.step(1'b0, 1);
    duty_is(9);
    ctl.step(1'b0, 8);
    duty_is(`BDR_DUTY_MIN_POS);
    ctl.step(1'b1, 9);
    duty_is(`BDR_DUTY_MAX_POS);
    ctl.step(1'b0, 1);
    // controller drops mode early: stepping must stay frozen
    pins(1'b1, 1'b0, 1'b0);
    ctl.step(1'b1, 1);
    period_is(`BDR_PERIOD_MIN);
    duty_is(9);
    pins(1'b1, 1'b0, 1'b1);
    ctl.step(1'b1, 1);
    duty_is(`BDR_DUTY_MAX_POS);
    pins(1'b1, 1'b0, 1'b0);
    ctl.step(1'b1, 1);
    period_is(`BDR_PERIOD_MIN + 1);
    $display("test duty done");
  endtask : t_duty

  // ----
  // main sequence
  // ----
  initial
  begin
    seen_hi = 1'b0;
    repeat (6) @(posedge clk_sys);
    `CHK("rst_leg_a", 2'b00, gate_leg_a)
    `CHK("rst_echo", 1'b0, rate_echo)
    `CHK("rst_wait", 1'b1, avs_waitrequest)
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs();
    t_off();
    t_direct();
    t_freq();
    t_duty();
    complete_run();
  end
endmodule : tb_bridge_drive_rate_duty_control
